// *** inc/switch_cfg_pkg.sv ***
// shared constants and types for the switch override and fault mask bank
package switch_cfg_pkg;
	localparam int NUM_SW = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 13;
	localparam logic [7:0] OFS_TIMEOUT_STATE = 8'h08;
	localparam logic [7:0] OFS_FORCE_CLOSED = 8'h09;
	localparam logic [7:0] OFS_FIRST_GROUP = 8'h0a;
	localparam logic [7:0] OFS_SECOND_GROUP = 8'h0b;
	localparam logic [7:0] OFS_FAULT_MASKS = 8'h0c;
	localparam logic [11:0] RST_SWITCH_FIELD = 12'h000;
	localparam logic [12:0] RST_FAULT_MASKS = 13'h0000;
	localparam int POS_OVERHEAT_ACTION = 12;
	localparam int POS_MASK_LINK_ERR = 6;
	localparam int POS_MASK_OPEN = 4;
	localparam int POS_MASK_SHORT = 3;
	localparam int POS_MASK_PUMP = 2;
	localparam int POS_MASK_RDEC = 1;
	localparam int POS_MASK_WARN = 0;
	localparam logic [12:0] MASK_REG_USED = 13'h105f;
	localparam logic [3:0] SEL_FIRST_GROUP = 4'h1;
	localparam logic [3:0] SEL_SECOND_GROUP = 4'h2;

	typedef enum logic [1:0] {
		GRP_FIRST_DUTY = 2'h0,
		GRP_SECOND_DUTY = 2'h1,
		GRP_PHASE_SHIFT = 2'h3,
		GRP_DIM_PERIOD = 2'h2
	} grp_kind_e;

	typedef struct packed {
		logic link_timeout;
		logic overheat_shutdown_flag;
		logic overheat_warning_flag;
		logic pump_not_ready_flag;
		logic resistor_decode_error_flag;
		logic link_error_flag;
	} status_flags_s;

	typedef struct packed {
		logic valid;
		grp_kind_e kind;
		logic [3:0] selector;
	} grp_txn_s;
endpackage : switch_cfg_pkg

// *** logic/switch_cfg_bank.sv ***
// override, group membership and fault mask register bank with switch control
`timescale 1ns/1ns
module switch_cfg_bank
	import switch_cfg_pkg::*;
#(
	parameter int SWITCHES = NUM_SW
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data_q,
	output logic rd_valid_q,
	input wire logic [SWITCHES-1:0] dim_close_req,
	output logic [SWITCHES-1:0] switch_closed_q,
	output logic [SWITCHES-1:0] detect_enable_q,
	input wire grp_txn_s grp_txn,
	output logic [SWITCHES-1:0] grp_accept_q,
	input wire status_flags_s flags,
	input wire logic [SWITCHES-1:0] open_string_fault_flag,
	input wire logic [SWITCHES-1:0] shorted_lamp_status_bits,
	output logic fault_output_low_out,
	output logic fault_output_low_oe
);

	logic [SWITCHES-1:0] timeout_fallback_switch_bits_q;
	logic [SWITCHES-1:0] force_closed_bits_q;
	logic [SWITCHES-1:0] first_group_member_bits_q;
	logic [SWITCHES-1:0] second_group_member_bits_q;
	logic [DATA_W-1:0] fault_masks_q;
	logic [SWITCHES-1:0] switch_closed_d;
	logic [SWITCHES-1:0] grp_accept_d;
	logic [SWITCHES-1:0] open_seen;
	logic [SWITCHES-1:0] short_seen;
	logic fault_d;
	logic fault_q;
	logic [DATA_W-1:0] rd_data_d;

	function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		hit = en && (a == ofs);
	endfunction : hit

	// widen a switch field into a register word
	function automatic logic [DATA_W-1:0] widen(
		input logic [SWITCHES-1:0] f);
		widen = {{(DATA_W-SWITCHES){1'b0}}, f};
	endfunction : widen

	// register writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			timeout_fallback_switch_bits_q <= RST_SWITCH_FIELD;
		end else if (hit(wr_en, wr_addr, OFS_TIMEOUT_STATE)) begin
			timeout_fallback_switch_bits_q <= wr_data[SWITCHES-1:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			force_closed_bits_q <= RST_SWITCH_FIELD;
		end else if (hit(wr_en, wr_addr, OFS_FORCE_CLOSED)) begin
			force_closed_bits_q <= wr_data[SWITCHES-1:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			first_group_member_bits_q <= RST_SWITCH_FIELD;
			second_group_member_bits_q <= RST_SWITCH_FIELD;
		end else begin
			if (hit(wr_en, wr_addr, OFS_FIRST_GROUP)) begin
				first_group_member_bits_q <= wr_data[SWITCHES-1:0];
			end
			if (hit(wr_en, wr_addr, OFS_SECOND_GROUP)) begin
				second_group_member_bits_q <= wr_data[SWITCHES-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_masks_q <= RST_FAULT_MASKS;
		end else if (hit(wr_en, wr_addr, OFS_FAULT_MASKS)) begin
			fault_masks_q <= wr_data & MASK_REG_USED;
		end
	end

	// register reads, reserved and unmapped read as zero
	always_comb begin
		rd_data_d = '0;
		unique case (rd_addr)
			OFS_TIMEOUT_STATE: rd_data_d = widen(timeout_fallback_switch_bits_q);
			OFS_FORCE_CLOSED: rd_data_d = widen(force_closed_bits_q);
			OFS_FIRST_GROUP: rd_data_d = widen(first_group_member_bits_q);
			OFS_SECOND_GROUP: rd_data_d = widen(second_group_member_bits_q);
			OFS_FAULT_MASKS: rd_data_d = fault_masks_q;
			default: rd_data_d = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
			if (rd_en) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	// switch state: overheat, then link timeout, then override, then dimming
	always_comb begin
		if (flags.overheat_shutdown_flag) begin
			switch_closed_d = fault_masks_q[POS_OVERHEAT_ACTION] ?
				'0 : '1;
		end else if (flags.link_timeout) begin
			switch_closed_d = timeout_fallback_switch_bits_q;
		end else begin
			switch_closed_d = force_closed_bits_q | dim_close_req;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			switch_closed_q <= '0;
			detect_enable_q <= '0;
		end else begin
			switch_closed_q <= switch_closed_d;
			detect_enable_q <= ~switch_closed_d;
		end
	end

	// group transaction acceptance
	always_comb begin
		grp_accept_d = '0;
		if (grp_txn.valid) begin
			unique case (grp_txn.kind)
				GRP_FIRST_DUTY: grp_accept_d = first_group_member_bits_q;
				GRP_SECOND_DUTY: grp_accept_d = second_group_member_bits_q;
				GRP_PHASE_SHIFT, GRP_DIM_PERIOD: begin
					if (grp_txn.selector == SEL_FIRST_GROUP) begin
						grp_accept_d = first_group_member_bits_q;
					end else if (grp_txn.selector == SEL_SECOND_GROUP) begin
						grp_accept_d = second_group_member_bits_q;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			grp_accept_q <= '0;
		end else begin
			grp_accept_q <= grp_accept_d;
		end
	end

	// lamp faults count only on switches that are open
	assign open_seen = open_string_fault_flag & detect_enable_q;
	assign short_seen = shorted_lamp_status_bits & detect_enable_q;

	always_comb begin
		fault_d = flags.link_timeout | flags.overheat_shutdown_flag;
		if (flags.link_error_flag && !fault_masks_q[POS_MASK_LINK_ERR]) begin
			fault_d = 1'b1;
		end
		if ((|open_seen) && !fault_masks_q[POS_MASK_OPEN]) begin
			fault_d = 1'b1;
		end
		if ((|short_seen) && !fault_masks_q[POS_MASK_SHORT]) begin
			fault_d = 1'b1;
		end
		if (flags.pump_not_ready_flag && !fault_masks_q[POS_MASK_PUMP]) begin
			fault_d = 1'b1;
		end
		if (flags.resistor_decode_error_flag &&
			!fault_masks_q[POS_MASK_RDEC]) begin
			fault_d = 1'b1;
		end
		if (flags.overheat_warning_flag && !fault_masks_q[POS_MASK_WARN]) begin
			fault_d = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_d;
		end
	end

	// open drain, low while a fault is flagged
	assign fault_output_low_out = 1'b0;
	assign fault_output_low_oe = fault_q;

	property p_force_closed;
		@(posedge clock) disable iff (!rstn)
		(!flags.overheat_shutdown_flag && !flags.link_timeout)
		|=> ((switch_closed_q & $past(force_closed_bits_q)) ==
			$past(force_closed_bits_q));
	endproperty
	a_force_closed: assert property (p_force_closed)
		else $error("overridden switch not held closed");

	property p_follow_dim;
		@(posedge clock) disable iff (!rstn)
		(!flags.overheat_shutdown_flag && !flags.link_timeout)
		|=> ((switch_closed_q & ~$past(force_closed_bits_q)) ==
			($past(dim_close_req) & ~$past(force_closed_bits_q)));
	endproperty
	a_follow_dim: assert property (p_follow_dim)
		else $error("switch without override left dimming control");

	property p_overheat;
		@(posedge clock) disable iff (!rstn)
		flags.overheat_shutdown_flag |=> (switch_closed_q ==
			($past(fault_masks_q[POS_OVERHEAT_ACTION]) ? '0 : '1));
	endproperty
	a_overheat: assert property (p_overheat)
		else $error("overheat action not applied");

	property p_timeout;
		@(posedge clock) disable iff (!rstn)
		(flags.link_timeout && !flags.overheat_shutdown_flag)
		|=> (switch_closed_q == $past(timeout_fallback_switch_bits_q));
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("fallback switch states not applied");

	property p_no_detect_closed;
		@(posedge clock) disable iff (!rstn)
		(flags == '0 && ((open_string_fault_flag | shorted_lamp_status_bits)
			& ~switch_closed_q) == '0) |=> !fault_output_low_oe;
	endproperty
	a_no_detect_closed: assert property (p_no_detect_closed)
		else $error("lamp fault on closed switch asserted fault pin");

	property p_first_duty;
		@(posedge clock) disable iff (!rstn)
		(grp_txn.valid && grp_txn.kind == GRP_FIRST_DUTY)
		|=> (grp_accept_q == $past(first_group_member_bits_q));
	endproperty
	a_first_duty: assert property (p_first_duty)
		else $error("first group duty acceptance wrong");

	property p_selector;
		@(posedge clock) disable iff (!rstn)
		(grp_txn.valid && grp_txn.kind inside {GRP_PHASE_SHIFT,
			GRP_DIM_PERIOD} && grp_txn.selector != SEL_FIRST_GROUP &&
			grp_txn.selector != SEL_SECOND_GROUP) |=> (grp_accept_q == '0);
	endproperty
	a_selector: assert property (p_selector)
		else $error("group accepted foreign selector");

	property p_second_sel;
		@(posedge clock) disable iff (!rstn)
		(grp_txn.valid && grp_txn.kind == GRP_DIM_PERIOD &&
			grp_txn.selector == SEL_SECOND_GROUP)
		|=> (grp_accept_q == $past(second_group_member_bits_q));
	endproperty
	a_second_sel: assert property (p_second_sel)
		else $error("second group selector acceptance wrong");

	property p_warn_fault;
		@(posedge clock) disable iff (!rstn)
		(flags.overheat_warning_flag && !fault_masks_q[POS_MASK_WARN])
		|=> fault_output_low_oe;
	endproperty
	a_warn_fault: assert property (p_warn_fault)
		else $error("unmasked warning did not assert fault pin");

	property p_link_masked;
		@(posedge clock) disable iff (!rstn)
		(flags == status_flags_s'(6'h01) && fault_masks_q[POS_MASK_LINK_ERR]
			&& open_seen == '0 && short_seen == '0) |=> !fault_output_low_oe;
	endproperty
	a_link_masked: assert property (p_link_masked)
		else $error("masked link error asserted fault pin");

	property p_readback;
		@(posedge clock) disable iff (!rstn)
		(wr_en && wr_addr == OFS_FORCE_CLOSED && !rd_en)
		##1 (rd_en && rd_addr == OFS_FORCE_CLOSED && !wr_en)
		|=> (rd_data_q == widen($past(wr_data[SWITCHES-1:0], 2)));
	endproperty
	a_readback: assert property (p_readback)
		else $error("override readback differs from write");

	property p_phase_first;
		@(posedge clock) disable iff (!rstn)
		(grp_txn.valid && grp_txn.kind == GRP_PHASE_SHIFT &&
			grp_txn.selector == SEL_FIRST_GROUP)
		|=> (grp_accept_q == $past(first_group_member_bits_q));
	endproperty
	a_phase_first: assert property (p_phase_first)
		else $error("first group phase shift acceptance wrong");

	property p_second_duty;
		@(posedge clock) disable iff (!rstn)
		(grp_txn.valid && grp_txn.kind == GRP_SECOND_DUTY)
		|=> (grp_accept_q == $past(second_group_member_bits_q));
	endproperty
	a_second_duty: assert property (p_second_duty)
		else $error("second group duty acceptance wrong");

	property p_open_fault;
		@(posedge clock) disable iff (!rstn)
		((|(open_string_fault_flag & detect_enable_q)) &&
			!fault_masks_q[POS_MASK_OPEN]) |=> fault_output_low_oe;
	endproperty
	a_open_fault: assert property (p_open_fault)
		else $error("unmasked open fault did not assert fault pin");

	property p_pump_fault;
		@(posedge clock) disable iff (!rstn)
		(flags.pump_not_ready_flag && !fault_masks_q[POS_MASK_PUMP])
		|=> fault_output_low_oe;
	endproperty
	a_pump_fault: assert property (p_pump_fault)
		else $error("unmasked pump flag did not assert fault pin");

endmodule : switch_cfg_bank

// *** test/host_model.sv ***
// host side model issuing register accesses at the falling edge
`timescale 1ns/1ns
module host_model
	import switch_cfg_pkg::*;
(
	input wire logic clock,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic rd_en,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] rd_data_q,
	input wire logic rd_valid_q
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 13'h0000;
		rd_en = 1'b0;
		rd_addr = 8'h00;
	end
	// released lines show the inverse of their last value
	task write_reg(input logic [7:0] a, input logic [12:0] d);
		@(negedge clock);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clock);
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask : write_reg
	// write, then read the same offset in the very next cycle
	task write_read(input logic [7:0] a, input logic [12:0] d,
		output logic [12:0] q, output logic v);
		@(negedge clock);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clock);
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clock);
		rd_en = 1'b0;
		rd_addr = ~a;
		q = rd_data_q;
		v = rd_valid_q;
	endtask : write_read
	task read_reg(input logic [7:0] a, output logic [12:0] d, output logic v);
		@(negedge clock);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clock);
		rd_en = 1'b0;
		rd_addr = ~a;
		d = rd_data_q;
		v = rd_valid_q;
	endtask : read_reg
endmodule : host_model

// *** test/test_switch_cfg_bank.sv ***
// self-checking testbench for the switch override and fault mask bank
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("wrong value at %0t got %h expected %h", $time, got, exp); \
	end \
end
module test_switch_cfg_bank
	import switch_cfg_pkg::*;
;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic wr_en, rd_en, rd_valid_q, oe_out, pin, rv;
	logic [7:0] wr_addr, rd_addr;
	logic [12:0] wr_data, rd_data_q, rd;
	logic [11:0] dim, closed, det, acc, open_f, short_f;
	grp_txn_s grp_txn;
	status_flags_s flags;
	int num_errors = 0;
	int comparisons = 0;

	always #5 clock = ~clock;

	switch_cfg_bank dut (.clock(clock), .rstn(rstn), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.dim_close_req(dim), .switch_closed_q(closed),
		.detect_enable_q(det), .grp_txn(grp_txn), .grp_accept_q(acc),
		.flags(flags), .open_string_fault_flag(open_f),
		.shorted_lamp_status_bits(short_f),
		.fault_output_low_out(oe_out), .fault_output_low_oe(pin));

	host_model host (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task settle;
		repeat (2) @(negedge clock);
	endtask : settle

	task rd_check(input logic [7:0] a, input logic [12:0] e);
		host.read_reg(a, rd, rv);
		`CHECK(rv, 1'b1)
		`CHECK(rd, e)
	endtask : rd_check

	task t_reset;
		for (int i = 8; i < 13; i++)
			rd_check(i[7:0], 13'h0000);
		$display("test reset values done");
	endtask : t_reset

	task t_regs;
		logic [12:0] e;
		for (int i = 8; i < 14; i++) begin
			e = (i == 12) ? MASK_REG_USED : (i == 13) ? 13'h0000 : 13'h0fff;
			host.write_read(i[7:0], 13'h1fff, rd, rv);
			`CHECK(rv, 1'b1)
			`CHECK(rd, e)
		end
		for (int i = 8; i < 13; i++)
			host.write_reg(i[7:0], 13'h0000);
		$display("test readback done");
	endtask : t_regs

	task t_override;
		dim = 12'h0a5;
		host.write_reg(OFS_FORCE_CLOSED, 13'h000f);
		settle;
		`CHECK(closed, 12'h0af)
		`CHECK(det, 12'hf50)
		open_f = 12'h00f;
		settle;
		`CHECK(pin, 1'b0)
		open_f = 12'h010;
		settle;
		`CHECK(pin, 1'b1)
		open_f = 12'h000;
		dim = 12'h000;
		host.write_reg(OFS_FORCE_CLOSED, 13'h0000);
		settle;
		$display("test override done");
	endtask : t_override

	task t_groups;
		logic [11:0] e;
		host.write_reg(OFS_FIRST_GROUP, 13'h0003);
		host.write_reg(OFS_SECOND_GROUP, 13'h0300);
		for (int k = 0; k < 4; k++) begin
			for (int s = 0; s < 4; s++) begin
				grp_txn = '{1'b1, grp_kind_e'(k[1:0]), s[3:0]};
				@(negedge clock);
				grp_txn.valid = 1'b0;
				if (k == 0 || (k > 1 && s == 1))
					e = 12'h003;
				else if (k == 1 || (k > 1 && s == 2))
					e = 12'h300;
				else
					e = 12'h000;
				`CHECK(acc, e)
				@(negedge clock);
				`CHECK(acc, 12'h000)
			end
		end
		host.write_reg(OFS_FIRST_GROUP, 13'h0000);
		host.write_reg(OFS_SECOND_GROUP, 13'h0000);
		$display("test groups done");
	endtask : t_groups

	task t_overheat;
		dim = 12'h0f0;
		flags.overheat_shutdown_flag = 1'b1;
		settle;
		`CHECK(closed, 12'hfff)
		`CHECK(pin, 1'b1)
		`CHECK(oe_out, 1'b0)
		host.write_reg(OFS_FAULT_MASKS, 13'h1000);
		settle;
		`CHECK(closed, 12'h000)
		flags.overheat_shutdown_flag = 1'b0;
		host.write_reg(OFS_FAULT_MASKS, 13'h0000);
		settle;
		`CHECK(closed, 12'h0f0)
		host.write_reg(OFS_TIMEOUT_STATE, 13'h05a5);
		flags.link_timeout = 1'b1;
		settle;
		`CHECK(closed, 12'h5a5)
		flags.link_timeout = 1'b0;
		dim = 12'h000;
		settle;
		$display("test overheat and timeout done");
	endtask : t_overheat

	task set_src(input int p, input logic v);
		case (p)
			6: flags.link_error_flag = v;
			4: open_f = {11'h000, v};
			3: short_f = {11'h000, v};
			2: flags.pump_not_ready_flag = v;
			1: flags.resistor_decode_error_flag = v;
			default: flags.overheat_warning_flag = v;
		endcase
	endtask : set_src

	task t_masks;
		int pos[6];
		pos = '{6, 4, 3, 2, 1, 0};
		for (int i = 0; i < 6; i++) begin
			for (int m = 0; m < 2; m++) begin
				host.write_reg(OFS_FAULT_MASKS, 13'(m) << pos[i]);
				set_src(pos[i], 1'b1);
				settle;
				`CHECK(pin, ~m[0])
				set_src(pos[i], 1'b0);
				settle;
			end
		end
		$display("test fault masks done");
	endtask : t_masks

	initial begin
		#200000;
		num_errors++;
		report_and_stop;
	end

	initial begin
		dim = 12'h000;
		open_f = 12'h000;
		short_f = 12'h000;
		grp_txn = '{1'b0, GRP_FIRST_DUTY, 4'h0};
		flags = '0;
		repeat (4) @(negedge clock);
		rstn = 1'b1;
		t_reset;
		t_regs;
		t_override;
		t_groups;
		t_overheat;
		t_masks;
		report_and_stop;
	end
endmodule : test_switch_cfg_bank
